//--- ttb_timebase.sv
`timescale 1ns/1ns
// Operation
// - Bit 2 enables channel 1 complementary output
// - Bit 3 sets complementary active level
// - Lock level 2 or 3 freezes it
// - Bit 4 is channel 2 enable
// - Bit 5 is channel 2 polarity
// - Bit 7 channel 2 complementary polarity, locked
// - Counter register at 0x24, resets zero
// - Counter clock is input over divisor+1
// - Prescaler at 0x28, resets zero
// - Reload limit at 0x2c, resets ones
// - Reload limit zero stops the counter
// - Repetition down count, update at zero
// - New repetition value used at update
// - Repetition at 0x30, low byte only
// - Input channel enable gates capture
// - Lock levels 0..3, level 2 guards polarities
module ttb_timebase #(
  parameter int CNT_W = 16,
  parameter int REP_W = 8
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  input  wire logic [7:0]             bus_addr,
  input  wire logic [15:0]            bus_wdata,
  input  wire logic                   bus_wr,
  input  wire logic                   bus_rd,
  output logic      [15:0]            bus_rdata,
  input  wire logic                   ch1_is_input,
  input  wire logic                   ch2_is_input,
  input  wire logic                   ch1_capture_evt,
  input  wire logic                   ch2_capture_evt,
  output ttb_pkg::ttb_chan_s          chan_cfg,
  output logic                        ch1_capture_en,
  output logic                        ch2_capture_en,
  output logic                        ch1_capture_stb,
  output logic                        ch2_capture_stb,
  output logic      [CNT_W-1:0]       capture_value,
  output logic                        update_evt,
  output logic                        counter_clock
);
  initial
  begin
    if (CNT_W != 16 || REP_W != 8)
      $error("ttb_timebase: only 16-bit counter and 8-bit repetition supported");
  end

  logic [15:0]      chen_reg;
  logic [15:0]      chen_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] presc_reg;
  logic [CNT_W-1:0] presc_next;
  logic [CNT_W-1:0] reload_reg;
  logic [CNT_W-1:0] reload_next;
  logic [REP_W-1:0] rep_reg;
  logic [REP_W-1:0] rep_next;
  logic [1:0]       lock_reg;
  logic [1:0]       lock_next;
  logic             lock_written_reg;
  logic             lock_written_next;
  logic             update_sticky_reg;
  logic             update_sticky_next;
  logic [15:0]      rdata_next;
  logic             tick;
  logic             update;

  // Address decode
  wire wr_chen   = bus_wr && (bus_addr == ttb_pkg::CHEN_OFFSET);
  wire wr_cnt    = bus_wr && (bus_addr == ttb_pkg::CNT_OFFSET);
  wire wr_presc  = bus_wr && (bus_addr == ttb_pkg::PRESC_OFFSET);
  wire wr_reload = bus_wr && (bus_addr == ttb_pkg::RELOAD_OFFSET);
  wire wr_rep    = bus_wr && (bus_addr == ttb_pkg::REP_OFFSET);
  wire wr_lock   = bus_wr && (bus_addr == ttb_pkg::LOCK_OFFSET);
  wire rd_stat   = bus_rd && (bus_addr == ttb_pkg::STAT_OFFSET);

  // Polarity bits are frozen from lock level 2 upward
  wire         pol_locked = (lock_reg >= ttb_pkg::LOCK_LVL2);
  wire [15:0]  chen_wmask = pol_locked ? (ttb_pkg::CHEN_WMASK & ~ttb_pkg::POL_MASK)
                                       : ttb_pkg::CHEN_WMASK;
  assign chen_next = wr_chen ? ((chen_reg & ~chen_wmask) | (bus_wdata & chen_wmask))
                             : chen_reg;

  // Lock field takes one write after reset, any level 0..3
  assign lock_next         = (wr_lock && !lock_written_reg) ? bus_wdata[9:8] : lock_reg;
  assign lock_written_next = lock_written_reg || wr_lock;

  // Counter: software write wins over counting, limit zero holds it
  wire counting = tick && (reload_reg != '0);
  wire wrap     = counting && (cnt_reg >= reload_reg);
  assign cnt_next = wr_cnt   ? bus_wdata :
                    wrap     ? '0 :
                    counting ? cnt_reg + 1'b1 : cnt_reg;

  assign presc_next  = wr_presc ? bus_wdata : presc_reg;
  assign reload_next = wr_reload ? bus_wdata : reload_reg;
  assign rep_next    = wr_rep ? bus_wdata[REP_W-1:0] : rep_reg;

  // Update flag: hardware set wins over a clearing read
  assign update_sticky_next = update || (update_sticky_reg && !rd_stat);

  // Read mux, unmapped offsets read zero
  always_comb
  begin
    rdata_next = 16'h0000;
    if (bus_rd)
    begin
      case (bus_addr)
        ttb_pkg::CHEN_OFFSET:   rdata_next = chen_reg & ttb_pkg::CHEN_WMASK;
        ttb_pkg::CNT_OFFSET:    rdata_next = cnt_reg;
        ttb_pkg::PRESC_OFFSET:  rdata_next = presc_reg;
        ttb_pkg::RELOAD_OFFSET: rdata_next = reload_reg;
        ttb_pkg::REP_OFFSET:    rdata_next = {8'h00, rep_reg};
        ttb_pkg::LOCK_OFFSET:   rdata_next = {6'h00, lock_reg, 8'h00};
        ttb_pkg::STAT_OFFSET:   rdata_next = {15'h0000, update_sticky_reg};
        default:                rdata_next = 16'h0000;
      endcase
    end
  end

  // Prescaler restarted by a divisor write so new rate starts cleanly
  ttb_presc #(
    .WIDTH (CNT_W)
  ) u_presc (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .divisor (presc_reg),
    .restart (wr_presc),
    .tick    (tick)
  );

  ttb_rep #(
    .WIDTH (REP_W)
  ) u_rep (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .wrap    (wrap),
    .preset  (rep_reg),
    .update  (update)
  );

  // Register state
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      chen_reg          <= ttb_pkg::CHEN_RESET;
      cnt_reg           <= ttb_pkg::CNT_RESET;
      presc_reg         <= ttb_pkg::PRESC_RESET;
      reload_reg        <= ttb_pkg::RELOAD_RESET;
      rep_reg           <= ttb_pkg::REP_RESET;
      lock_reg          <= ttb_pkg::LOCK_RESET;
      lock_written_reg  <= 1'b0;
      update_sticky_reg <= 1'b0;
    end
    else
    begin
      chen_reg          <= chen_next;
      cnt_reg           <= cnt_next;
      presc_reg         <= presc_next;
      reload_reg        <= reload_next;
      rep_reg           <= rep_next;
      lock_reg          <= lock_next;
      lock_written_reg  <= lock_written_next;
      update_sticky_reg <= update_sticky_next;
    end
  end

  // Registered outputs; capture strobes need enable and input mode
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      bus_rdata       <= 16'h0000;
      chan_cfg        <= '0;
      ch1_capture_en  <= 1'b0;
      ch2_capture_en  <= 1'b0;
      ch1_capture_stb <= 1'b0;
      ch2_capture_stb <= 1'b0;
      capture_value   <= '0;
      update_evt      <= 1'b0;
      counter_clock   <= 1'b0;
    end
    else
    begin
      bus_rdata       <= rdata_next;
      chan_cfg        <= {chen_next[ttb_pkg::CH1_EN_BIT], chen_next[ttb_pkg::CH1_POL_BIT],
                          chen_next[ttb_pkg::CH1_CEN_BIT], chen_next[ttb_pkg::CH1_CPOL_BIT],
                          chen_next[ttb_pkg::CH2_EN_BIT], chen_next[ttb_pkg::CH2_POL_BIT],
                          chen_next[ttb_pkg::CH2_CPOL_BIT]};
      ch1_capture_en  <= ch1_is_input && chen_next[ttb_pkg::CH1_EN_BIT];
      ch2_capture_en  <= ch2_is_input && chen_next[ttb_pkg::CH2_EN_BIT];
      ch1_capture_stb <= ch1_capture_evt && ch1_is_input && chen_reg[ttb_pkg::CH1_EN_BIT];
      ch2_capture_stb <= ch2_capture_evt && ch2_is_input && chen_reg[ttb_pkg::CH2_EN_BIT];
      capture_value   <= cnt_reg;
      update_evt      <= update;
      counter_clock   <= tick;
    end
  end

  // Assertions
  sequence s_locked_pol_write;
    pol_locked && wr_chen;
  endsequence

  AST_LOCK_HOLDS_POL: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_locked_pol_write |=> ((chen_reg & ttb_pkg::POL_MASK) ==
                            ($past(chen_reg) & ttb_pkg::POL_MASK)))
    else $error("polarity bit changed while locked");

  AST_UNLOCK_WRITES: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_chen && !pol_locked) |=> (chen_reg[7:0] == ($past(bus_wdata[7:0]) & 8'hbf)))
    else $error("channel register write lost");

  AST_RESERVED_ZERO: assert property (@(posedge clk_sys) disable iff (!rstn)
    (bus_rd && bus_addr == ttb_pkg::CHEN_OFFSET) |=> (bus_rdata[15:6] ==? 10'b00000000x0))
    else $error("reserved channel bits read nonzero");

  AST_ZERO_LIMIT_HOLD: assert property (@(posedge clk_sys) disable iff (!rstn)
    (reload_reg == '0 && !wr_cnt) |=> (cnt_reg == $past(cnt_reg)))
    else $error("counter moved with zero reload limit");

  AST_WRAP_ZERO: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wrap && !wr_cnt) |=> (cnt_reg == '0))
    else $error("counter did not wrap to zero");

  AST_COUNT_UP: assert property (@(posedge clk_sys) disable iff (!rstn)
    (counting && !wrap && !wr_cnt) |=> (cnt_reg == $past(cnt_reg) + 16'h0001))
    else $error("counter did not step up");

  AST_REP_HIGH_ZERO: assert property (@(posedge clk_sys) disable iff (!rstn)
    (bus_rd && bus_addr == ttb_pkg::REP_OFFSET) |=> (bus_rdata[15:8] == 8'h00))
    else $error("repetition upper byte nonzero");

  AST_UPDATE_ON_WRAP: assert property (@(posedge clk_sys) disable iff (!rstn)
    update |-> wrap ##1 update_evt)
    else $error("update without wrap or not signalled");

  AST_CAPTURE_GATE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ch1_capture_evt && !chen_reg[ttb_pkg::CH1_EN_BIT]) |=> !ch1_capture_stb)
    else $error("capture strobe with channel disabled");

  AST_RESET_VALUES: assert property (@(posedge clk_sys)
    $rose(rstn) |-> (reload_reg == 16'hffff && presc_reg == 16'h0000 && cnt_reg == 16'h0000))
    else $error("wrong reset values");

  // Read data only stands in the cycle after a read strobe
  AST_RDATA_IDLE: assert property (@(posedge clk_sys) disable iff (!rstn)
    !bus_rd |=> (bus_rdata == 16'h0000))
    else $error("read data not zero without a read");

  AST_CNT_READ: assert property (@(posedge clk_sys) disable iff (!rstn)
    (bus_rd && bus_addr == ttb_pkg::CNT_OFFSET) |=> (bus_rdata == $past(cnt_reg)))
    else $error("counter read mismatch");

  AST_PRESC_READ: assert property (@(posedge clk_sys) disable iff (!rstn)
    (bus_rd && bus_addr == ttb_pkg::PRESC_OFFSET) |=> (bus_rdata == $past(presc_reg)))
    else $error("prescaler read mismatch");

  AST_RELOAD_READ: assert property (@(posedge clk_sys) disable iff (!rstn)
    (bus_rd && bus_addr == ttb_pkg::RELOAD_OFFSET) |=> (bus_rdata == $past(reload_reg)))
    else $error("reload limit read mismatch");

  AST_REP_READ: assert property (@(posedge clk_sys) disable iff (!rstn)
    (bus_rd && bus_addr == ttb_pkg::REP_OFFSET) |=> (bus_rdata[7:0] == $past(rep_reg)))
    else $error("repetition read mismatch");

  // Software writes land on the next edge
  AST_CNT_WRITE: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_cnt |=> (cnt_reg == $past(bus_wdata)))
    else $error("counter write lost");

  AST_PRESC_WRITE: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_presc |=> (presc_reg == $past(bus_wdata)))
    else $error("prescaler write lost");

  AST_RELOAD_WRITE: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_reload |=> (reload_reg == $past(bus_wdata)))
    else $error("reload limit write lost");

  AST_REP_WRITE: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_rep |=> (rep_reg == $past(bus_wdata[7:0])))
    else $error("repetition write lost");

  // Exported fields track the register bit for bit
  AST_CFG_COMP_EN: assert property (@(posedge clk_sys) disable iff (!rstn)
    chan_cfg.ch1_comp_out_enable == chen_reg[ttb_pkg::CH1_CEN_BIT])
    else $error("complementary enable not exported");

  AST_CFG_COMP_POL: assert property (@(posedge clk_sys) disable iff (!rstn)
    chan_cfg.ch1_comp_polarity == chen_reg[ttb_pkg::CH1_CPOL_BIT])
    else $error("complementary polarity not exported");

  AST_CFG_CH2_EN: assert property (@(posedge clk_sys) disable iff (!rstn)
    chan_cfg.ch2_enable == chen_reg[ttb_pkg::CH2_EN_BIT])
    else $error("channel 2 enable not exported");

  AST_CFG_CH2_POL: assert property (@(posedge clk_sys) disable iff (!rstn)
    chan_cfg.ch2_polarity == chen_reg[ttb_pkg::CH2_POL_BIT])
    else $error("channel 2 polarity not exported");

  AST_CFG_CH2_CPOL: assert property (@(posedge clk_sys) disable iff (!rstn)
    chan_cfg.ch2_comp_polarity == chen_reg[ttb_pkg::CH2_CPOL_BIT])
    else $error("channel 2 complementary polarity not exported");

  // Reserved bits can never be set by a write
  AST_CHEN_RESERVED: assert property (@(posedge clk_sys) disable iff (!rstn)
    (chen_reg[6] == 1'b0) && (chen_reg[15:8] == 8'h00))
    else $error("reserved channel bit set");

  // Capture enable levels follow input mode and enable bit
  AST_CAP_EN1: assert property (@(posedge clk_sys) disable iff (!rstn)
    1'b1 |=> (ch1_capture_en == ($past(ch1_is_input) && chen_reg[ttb_pkg::CH1_EN_BIT])))
    else $error("channel 1 capture enable wrong");

  AST_CAP_EN2: assert property (@(posedge clk_sys) disable iff (!rstn)
    1'b1 |=> (ch2_capture_en == ($past(ch2_is_input) && chen_reg[ttb_pkg::CH2_EN_BIT])))
    else $error("channel 2 capture enable wrong");

  AST_CAP_GATE2: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ch2_capture_evt && !chen_reg[ttb_pkg::CH2_EN_BIT]) |=> !ch2_capture_stb)
    else $error("channel 2 strobe with channel disabled");

  // An enabled input capture strobes and carries the counter
  sequence s_ch1_capture_req;
    ch1_capture_evt && ch1_is_input && chen_reg[ttb_pkg::CH1_EN_BIT];
  endsequence

  AST_CAP_STB_ON: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_ch1_capture_req |=> (ch1_capture_stb && capture_value == $past(cnt_reg)))
    else $error("enabled capture did not strobe the counter");

  // Counter clock output and prescaler restart
  AST_TICK_OUT: assert property (@(posedge clk_sys) disable iff (!rstn)
    tick |=> counter_clock)
    else $error("counter clock pulse missing");

  AST_RESTART_NO_TICK: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_presc |-> !tick)
    else $error("tick during prescaler restart");

  AST_NO_TICK_HOLD: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!tick && !wr_cnt) |=> (cnt_reg == $past(cnt_reg)))
    else $error("counter moved without a counter clock");

  // Lock is write-once; the flag set wins over a clearing read
  AST_LOCK_ONCE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_lock && lock_written_reg) |=> (lock_reg == $past(lock_reg)))
    else $error("lock level changed after first write");

  AST_STICKY_SET: assert property (@(posedge clk_sys) disable iff (!rstn)
    update |=> update_sticky_reg)
    else $error("update flag not set");
endmodule

//--- ttb_pkg.sv
package ttb_pkg;
  // Register offsets
  localparam logic [7:0] CHEN_OFFSET   = 8'h20;
  localparam logic [7:0] CNT_OFFSET    = 8'h24;
  localparam logic [7:0] PRESC_OFFSET  = 8'h28;
  localparam logic [7:0] RELOAD_OFFSET = 8'h2c;
  localparam logic [7:0] REP_OFFSET    = 8'h30;
  localparam logic [7:0] LOCK_OFFSET   = 8'h44;
  localparam logic [7:0] STAT_OFFSET   = 8'h48;
  // Field positions in channel_enable_polarity
  localparam int CH1_EN_BIT     = 0;
  localparam int CH1_POL_BIT    = 1;
  localparam int CH1_CEN_BIT    = 2;
  localparam int CH1_CPOL_BIT   = 3;
  localparam int CH2_EN_BIT     = 4;
  localparam int CH2_POL_BIT    = 5;
  localparam int CH2_CPOL_BIT   = 7;
  localparam int LOCK_LSB       = 8;
  // Writable mask of channel register and polarity mask
  localparam logic [15:0] CHEN_WMASK = 16'h00bf;
  localparam logic [15:0] POL_MASK   = 16'h00aa;
  // Reset values
  localparam logic [15:0] CNT_RESET    = 16'h0000;
  localparam logic [15:0] PRESC_RESET  = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'hffff;
  localparam logic [7:0]  REP_RESET    = 8'h00;
  localparam logic [15:0] CHEN_RESET   = 16'h0000;
  localparam logic [1:0]  LOCK_RESET   = 2'h0;
  localparam logic [1:0]  LOCK_LVL2    = 2'h2;
  // Channel outputs gathered
  typedef struct packed {
    logic ch1_enable;
    logic ch1_polarity;
    logic ch1_comp_out_enable;
    logic ch1_comp_polarity;
    logic ch2_enable;
    logic ch2_polarity;
    logic ch2_comp_polarity;
  } ttb_chan_s;
endpackage

//--- ttb_presc.sv
`timescale 1ns/1ns
module ttb_presc #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] divisor,
  input  wire logic             restart,
  output logic                  tick
);
  initial
  begin
    if (WIDTH < 1 || WIDTH > 32)
      $error("ttb_presc: WIDTH out of range");
  end

  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  wire              at_end = (cnt_reg >= divisor);

  // Tick once every divisor+1 clocks; restart realigns the phase
  assign cnt_next = (restart || at_end) ? '0 : cnt_reg + 1'b1;
  assign tick     = at_end && !restart;

  // Divider phase
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end

  AST_TICK_SPACING: assert property (@(posedge clk_sys) disable iff (!rstn)
    (tick && divisor == '0 && !restart) |=> (tick || restart))
    else $error("prescaler with zero divisor must tick every clock");
endmodule

//--- ttb_rep.sv
`timescale 1ns/1ns
module ttb_rep #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic             wrap,
  input  wire logic [WIDTH-1:0] preset,
  output logic                  update
);
  initial
  begin
    if (WIDTH < 1 || WIDTH > 16)
      $error("ttb_rep: WIDTH out of range");
  end

  logic [WIDTH-1:0] left_reg;
  logic [WIDTH-1:0] left_next;

  // Update when the down count is at zero; reload then uses the new preset
  assign update    = wrap && (left_reg == '0);
  assign left_next = update ? preset : (wrap ? left_reg - 1'b1 : left_reg);

  // Remaining wraps before the next update
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      left_reg <= '0;
    else
      left_reg <= left_next;
  end

  AST_REP_RELOAD: assert property (@(posedge clk_sys) disable iff (!rstn)
    update |=> (left_reg == $past(preset)))
    else $error("repetition count did not reload from preset");
endmodule

//--- testbench.sv
`timescale 1ns/1ns
module testbench;
  logic               clk_sys;
  logic               rstn;
  logic [7:0]         bus_addr;
  logic [15:0]        bus_wdata;
  logic               bus_wr;
  logic               bus_rd;
  logic [15:0]        bus_rdata;
  logic               ch1_is_input;
  logic               ch2_is_input;
  logic               ch1_capture_evt;
  logic               ch2_capture_evt;
  ttb_pkg::ttb_chan_s chan_cfg;
  logic               ch1_capture_en;
  logic               ch2_capture_en;
  logic               ch1_capture_stb;
  logic               ch2_capture_stb;
  logic [15:0]        capture_value;
  logic               update_evt;
  logic               counter_clock;
  int                 fails;
  int                 samples_checked;
  int                 n;
  int                 m_chen;
  int                 m_psc;
  int                 m_rld;
  int                 m_rep;
  logic [31:0]        lfsr_state;
  logic [15:0]        pats [4] = '{16'hffff, 16'h00a8, 16'h0014, 16'h0005};

  ttb_timebase ttb_timebase_inst (
    .clk_sys         (clk_sys),
    .rstn            (rstn),
    .bus_addr        (bus_addr),
    .bus_wdata       (bus_wdata),
    .bus_wr          (bus_wr),
    .bus_rd          (bus_rd),
    .bus_rdata       (bus_rdata),
    .ch1_is_input    (ch1_is_input),
    .ch2_is_input    (ch2_is_input),
    .ch1_capture_evt (ch1_capture_evt),
    .ch2_capture_evt (ch2_capture_evt),
    .chan_cfg        (chan_cfg),
    .ch1_capture_en  (ch1_capture_en),
    .ch2_capture_en  (ch2_capture_en),
    .ch1_capture_stb (ch1_capture_stb),
    .ch2_capture_stb (ch2_capture_stb),
    .capture_value   (capture_value),
    .update_evt      (update_evt),
    .counter_clock   (counter_clock)
  );

  // Free-running 100 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Fixed-seed pseudo-random source
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected channel fields, gap at bit 6 is reserved
  function automatic logic [6:0] chan_exp(input int v);
    return {v[0], v[1], v[2], v[3], v[4], v[5], v[7]};
  endfunction

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_cyc(input int got, input int exp);
    samples_checked++;
    if (got != exp)
    begin
      fails++;
      $display("ERROR t=%0t cycles %h exp %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One-cycle write strobe; entered just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge clk_sys);
    bus_wr    <= 1'b0;
    // Idle edge so a following write never re-drives the strobe in one step
    @(posedge clk_sys);
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge clk_sys);
    bus_rd   <= 1'b0;
    @(posedge clk_sys);
    chk_val(bus_rdata, exp);
  endtask

  // Bounded wait for the next pulse; returns edges counted
  task automatic wait_pulse(input bit upd, output int cnt);
    cnt = 0;
    do
    begin
      @(posedge clk_sys);
      cnt++;
    end
    while ((upd ? update_evt : counter_clock) !== 1'b1 && cnt < 400);
  endtask

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    fails++;
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    rstn = 1'b0;
    bus_addr = 8'h00;
    bus_wdata = 16'h0000;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    ch1_is_input = 1'b0;
    ch2_is_input = 1'b0;
    ch1_capture_evt = 1'b0;
    ch2_capture_evt = 1'b0;
    lfsr_state = 32'h34e5;
    m_chen = 0;
    m_psc = 0;
    m_rld = 'hffff;
    m_rep = 0;
    fails = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rd_chk(ttb_pkg::CHEN_OFFSET, 16'(m_chen));
    rd_chk(ttb_pkg::PRESC_OFFSET, 16'(m_psc));
    rd_chk(ttb_pkg::RELOAD_OFFSET, 16'(m_rld));
    rd_chk(ttb_pkg::REP_OFFSET, 16'(m_rep));
    rd_chk(8'h3c, 16'h0000);
    // Channel fields, reserved bits must read back zero
    foreach (pats[i])
    begin
      wr(ttb_pkg::CHEN_OFFSET, pats[i]);
      m_chen = int'(pats[i] & ttb_pkg::CHEN_WMASK);
      rd_chk(ttb_pkg::CHEN_OFFSET, 16'(m_chen));
      chk_val(16'(chan_cfg), 16'(chan_exp(m_chen)));
    end
    // Only the low byte of the repetition register exists
    wr(ttb_pkg::REP_OFFSET, 16'hab01);
    m_rep = 1;
    rd_chk(ttb_pkg::REP_OFFSET, 16'h0001);
    wr(ttb_pkg::PRESC_OFFSET, 16'h0002);
    m_psc = 2;
    wr(ttb_pkg::RELOAD_OFFSET, 16'h0003);
    m_rld = 3;
    wait_pulse(1'b0, n);
    wait_pulse(1'b0, n);
    chk_cyc(n, m_psc + 1);
    // First update may be partial; measure the next full period
    wait_pulse(1'b1, n);
    wait_pulse(1'b1, n);
    chk_cyc(n, (m_psc + 1) * (m_rld + 1) * (m_rep + 1));
    // A new repetition value waits for the following update
    wr(ttb_pkg::REP_OFFSET, 16'h0002);
    wait_pulse(1'b1, n);
    chk_cyc(n + 2, (m_psc + 1) * (m_rld + 1) * (m_rep + 1));
    m_rep = 2;
    wait_pulse(1'b1, n);
    chk_cyc(n, (m_psc + 1) * (m_rld + 1) * (m_rep + 1));
    // Sticky update flag reads one, then clears on that read
    rd_chk(ttb_pkg::STAT_OFFSET, 16'h0001);
    rd_chk(ttb_pkg::STAT_OFFSET, 16'h0000);
    // Zero reload freezes a random counter value
    wr(ttb_pkg::RELOAD_OFFSET, 16'h0000);
    lfsr_state = lfsr_next(lfsr_state);
    wr(ttb_pkg::CNT_OFFSET, lfsr_state[15:0]);
    repeat (6) @(posedge clk_sys);
    rd_chk(ttb_pkg::CNT_OFFSET, lfsr_state[15:0]);
    // Capture gated by each channel's enable bit
    ch1_is_input <= 1'b1;
    ch2_is_input <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk_val({ch1_capture_en, ch2_capture_en}, {m_chen[0], m_chen[4]});
    ch1_capture_evt <= 1'b1;
    ch2_capture_evt <= 1'b1;
    @(posedge clk_sys);
    ch1_capture_evt <= 1'b0;
    ch2_capture_evt <= 1'b0;
    @(posedge clk_sys);
    chk_val({ch1_capture_stb, ch2_capture_stb}, {m_chen[0], m_chen[4]});
    chk_val(capture_value, lfsr_state[15:0]);
    // Lock level 2 keeps polarity bits, other fields still writable
    wr(ttb_pkg::LOCK_OFFSET, {6'h00, ttb_pkg::LOCK_LVL2, 8'h00});
    wr(ttb_pkg::CHEN_OFFSET, 16'h00ff);
    m_chen = (m_chen & int'(ttb_pkg::POL_MASK))
           | int'(16'h00ff & ttb_pkg::CHEN_WMASK & ~ttb_pkg::POL_MASK);
    rd_chk(ttb_pkg::CHEN_OFFSET, 16'(m_chen));
    chk_val(16'(chan_cfg), 16'(chan_exp(m_chen)));
    // Lock field accepts only its first write after reset
    wr(ttb_pkg::LOCK_OFFSET, 16'h0300);
    rd_chk(ttb_pkg::LOCK_OFFSET, {6'h00, ttb_pkg::LOCK_LVL2, 8'h00});
    report_and_stop();
  end
endmodule
